// >>> core/adccs_params.svh
// constants for the conversion control and calibration block
// Overview of operation
// RULE_01: reset on the falling sclk edge shifting a zero after 1023 ones
// RULE_02: four-wire only, reset at chip select rise after 1024 ones
// RULE_03: any write to addresses 04h through 0Eh restarts the conversion
// RULE_04: two-bit field picks synchronized, start/stop or one-shot control
// RULE_05: host keeps start pin low when controlling conversions by commands
// RULE_06: first result after any synchronisation waits for the filter latency
// RULE_07: synchronized mode converts always and resyncs on a start rise
// RULE_08: start rise within one clock of a period multiple does not resync
// RULE_09: start/stop runs from pin high or start bit, stops after conversion
// RULE_10: host writes zero to control before setting the start bit
// RULE_11: start/stop data-ready goes high at start, low per result
// RULE_12: a start pulse or repeated start bit restarts the conversion
// RULE_13: stopped in standby data-ready rises after three clocks, else on readout
// RULE_14: unread result gives a short high pulse before the next fall
// RULE_15: one-shot start triggers one conversion, data-ready high then low
// RULE_16: one-shot conversion is never interrupted, stop bit does nothing
// RULE_17: one-shot standby data-ready rises after three clocks, else next start
// RULE_18: three-bit delay waits before the first conversion only
// RULE_19: subtract offset, multiply by gain, divide by unity constant
// RULE_20: round to 16 or 24 bits and saturate at full scale
// RULE_21: offset is signed 24 bits from 09h high, 0Ah mid, 0Bh low
// RULE_22: gain is unsigned 24 bits, 400000h unity, from 0Ch to 0Eh
// RULE_23: serial input bits are sampled on falling sclk edges
// RULE_24: with standby enabled, stop enters standby and start leaves it
// RULE_25: ones counter clears on a zero before the run is complete
// RULE_26: new mode and calibration apply at the restart they cause; code latches pre-write values, new ones apply at the next restart
`ifndef ADCCS_PARAMS_SVH
`define ADCCS_PARAMS_SVH
`define ADDR_CTRL    8'h02
`define ADDR_SETB    8'h06
`define ADDR_SETC    8'h07
`define ADDR_OFS_HI  8'h09
`define ADDR_OFS_MID 8'h0a
`define ADDR_OFS_LO  8'h0b
`define ADDR_GN_HI   8'h0c
`define ADDR_GN_MID  8'h0d
`define ADDR_GN_LO   8'h0e
`define RESTART_LO   8'h04
`define RESTART_HI   8'h0e
`define CTRL_START   0
`define CTRL_STOP    1
`define SETB_PD      2
`define SETC_RES24   3
`define GAIN_UNITY   24'h400000
`define SETC_RST     8'h08
`define ONES_P1      11'd1023
`define ONES_P2      11'd1024
`define READ_FALLS   3'd4
`define CONV_PERIOD  16'd64
`define FILT_LAT     16'd160
`define STBY_EXTRA   16'd24
`define DLY_UNIT     16'd32
`define RESULT_AVAILABLE_N_HOLD    2'd3
`endif

// >>> core/adccs_pkg.sv
// types for the conversion control and calibration block
package adccs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_SETTLE = 2'b11,
    ST_RUN    = 2'b10
  } adccs_state_t;
  typedef enum logic [1:0] {
    MD_SYNC    = 2'b00,
    MD_STSTOP  = 2'b01,
    MD_ONESHOT = 2'b10,
    MD_RSVD    = 2'b11
  } adccs_mode_t;
endpackage

// >>> core/adccs_core.sv
// conversion control, reset patterns and output calibration
`timescale 1ns/1ps
`include "adccs_params.svh"
module adccs_core (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        sdi,
  input  wire logic        startPin,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic [23:0] rawData,
  output logic      [23:0] resultData,
  output logic             resultAvailableN,
  output logic             standbyOn,
  output logic             deviceResetPulse
);

  function automatic logic [23:0] calibrate(input logic [23:0] raw,
                                            input logic [23:0] ofs,
                                            input logic [23:0] gain,
                                            input logic        res24);
    logic signed [24:0] d;
    logic signed [49:0] p;
    logic signed [49:0] r;
    logic [23:0]        o;
    d = $signed({raw[23], raw}) - $signed({ofs[23], ofs});
    p = d * $signed({1'b0, gain});
    if (res24) begin
      r = (p + 50'sd2097152) >>> 22;
      if ((&r[49:23]) || !(|r[49:23]))
        o = r[23:0];
      else
        o = r[49] ? 24'h800000 : 24'h7fffff;
    end else begin
      r = (p + 50'sd536870912) >>> 30;
      if ((&r[49:15]) || !(|r[49:15]))
        o = {{8{r[15]}}, r[15:0]};
      else
        o = r[49] ? 24'hff8000 : 24'h007fff;
    end
    return o;
  endfunction

  // ---------------- link side, sclk domain ----------------
  logic [10:0] onesCnt;
  logic        longRun;
  logic        p1Tgl;
  logic        clrS1;
  logic        clrS2;
  logic        clrAck;
  logic [2:0]  fallCnt;
  logic        readTgl;
  logic        clrTgl;

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      clrS1 <= 1'b0;
      clrS2 <= 1'b0;
    end else begin
      clrS1 <= clrTgl;
      clrS2 <= clrS1;
    end
  end

  // pattern counter, sampled on falling edges
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      onesCnt <= 11'd0;
      longRun <= 1'b0;
      p1Tgl   <= 1'b0;
      clrAck  <= 1'b0;
    end else if (clrS2 != clrAck) begin
      // the bit on this edge still counts, but ones on the two falling edges before it go to the old count and are lost
      onesCnt <= {10'd0, sdi};
      longRun <= 1'b0;
      clrAck  <= clrS2;
    end else if (sdi) begin //RULE_23
      if (onesCnt != `ONES_P2)
        onesCnt <= onesCnt + 11'd1;
      longRun <= (onesCnt >= `ONES_P2 - 11'd1);
    end else begin
      if (onesCnt >= `ONES_P1)
        p1Tgl <= ~p1Tgl; //RULE_01
      onesCnt <= 11'd0; //RULE_25
      longRun <= 1'b0;
    end
  end

  pattern1_a: assert property (@(negedge sclk) disable iff (!nrst) //RULE_01
    (!sdi && onesCnt >= `ONES_P1 && clrS2 == clrAck) |=> (p1Tgl != $past(p1Tgl)))
    else $error("pattern one not flagged");

  // frame readout edge count, cleared while chip select is high
  always_ff @(negedge sclk or negedge nrst or posedge csN) begin
    if (!nrst) begin
      fallCnt <= 3'd0;
    end else if (csN) begin
      fallCnt <= 3'd0;
    end else if (fallCnt != `READ_FALLS) begin
      fallCnt <= fallCnt + 3'd1;
    end
  end

  // the eighth edge is the fourth falling one
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst)
      readTgl <= 1'b0;
    else if (!csN && fallCnt == `READ_FALLS - 3'd1)
      readTgl <= ~readTgl;
  end

  // ---------------- crossings into mclk ----------------
  logic [2:0] p1Sync;
  logic [2:0] rdSync;
  logic [1:0] longSync;
  logic [2:0] csSync;
  logic [2:0] stSync;
  logic       softRst;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      p1Sync   <= 3'b000;
      rdSync   <= 3'b000;
      longSync <= 2'b00;
      csSync   <= 3'b111;
      stSync   <= 3'b000;
    end else begin
      p1Sync   <= {p1Sync[1:0], p1Tgl};
      rdSync   <= {rdSync[1:0], readTgl};
      longSync <= {longSync[0], longRun};
      csSync   <= {csSync[1:0], csN};
      stSync   <= {stSync[1:0], startPin};
    end
  end

  logic p1Evt;
  logic readEvt;
  logic csRise;
  logic startRise;
  logic startFall;
  assign p1Evt     = p1Sync[2] ^ p1Sync[1];
  assign readEvt   = rdSync[2] ^ rdSync[1];
  assign csRise    = csSync[1] & ~csSync[2];
  assign startRise = stSync[1] & ~stSync[2];
  assign startFall = ~stSync[1] & stSync[2];

  // 3-wire never raises chip select, so pattern two cannot fire there
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      softRst <= 1'b0;
      clrTgl  <= 1'b0;
    end else begin
      softRst <= p1Evt | (csRise & longSync[1]); //RULE_01 RULE_02
      // pattern one ends on a zero that already clears the count
      if (csRise & longSync[1])
        clrTgl <= ~clrTgl;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      deviceResetPulse <= 1'b0;
    else
      deviceResetPulse <= softRst;
  end

  pattern2_a: assert property (@(posedge mclk) disable iff (!nrst) //RULE_02
    (csRise && longSync[1]) |=> ##1 deviceResetPulse)
    else $error("pattern two reset missing");

  // ---------------- registers ----------------
  logic [7:0] setB;
  logic [7:0] setC;
  logic [23:0] ofsReg;
  logic [23:0] gainReg;
  logic       cfgWr;
  logic       ctrlWr;
  assign cfgWr  = regWrEn && regAddr >= `RESTART_LO && regAddr <= `RESTART_HI;
  assign ctrlWr = regWrEn && regAddr == `ADDR_CTRL;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      setB    <= 8'h00;
      setC    <= `SETC_RST;
      ofsReg  <= 24'h000000;
      gainReg <= `GAIN_UNITY;
    end else if (softRst) begin
      setB    <= 8'h00;
      setC    <= `SETC_RST;
      ofsReg  <= 24'h000000;
      gainReg <= `GAIN_UNITY;
    end else if (regWrEn) begin
      unique case (regAddr)
        `ADDR_SETB:    setB           <= regWrData;
        `ADDR_SETC:    setC           <= regWrData;
        `ADDR_OFS_HI:  ofsReg[23:16]  <= regWrData; //RULE_21
        `ADDR_OFS_MID: ofsReg[15:8]   <= regWrData;
        `ADDR_OFS_LO:  ofsReg[7:0]    <= regWrData;
        `ADDR_GN_HI:   gainReg[23:16] <= regWrData; //RULE_22
        `ADDR_GN_MID:  gainReg[15:8]  <= regWrData;
        `ADDR_GN_LO:   gainReg[7:0]   <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        `ADDR_CTRL:    regRdData <= {6'h00, ~resultAvailableN, standbyOn};
        `ADDR_SETB:    regRdData <= setB;
        `ADDR_SETC:    regRdData <= setC;
        `ADDR_OFS_HI:  regRdData <= ofsReg[23:16];
        `ADDR_OFS_MID: regRdData <= ofsReg[15:8];
        `ADDR_OFS_LO:  regRdData <= ofsReg[7:0];
        `ADDR_GN_HI:   regRdData <= gainReg[23:16];
        `ADDR_GN_MID:  regRdData <= gainReg[15:8];
        `ADDR_GN_LO:   regRdData <= gainReg[7:0];
        default:       regRdData <= 8'h00;
      endcase
    end
  end

  // ---------------- conversion control ----------------
  adccs_pkg::adccs_state_t state;
  adccs_pkg::adccs_mode_t  actMode;
  logic [15:0] cnt;
  logic [23:0] actOfs;
  logic [23:0] actGain;
  logic        actRes24;
  logic        actPd;
  logic        stopPend;
  logic [15:0] startPhase;
  logic        haveRise;
  logic [1:0]  holdCnt;
  logic        busy;
  logic        done;
  logic        goIdle;
  logic        aligned;
  logic        startBitWr;
  logic        stopBitWr;
  logic        goStart;

  assign busy       = state != adccs_pkg::ST_IDLE;
  assign done       = (state == adccs_pkg::ST_SETTLE || state == adccs_pkg::ST_RUN) &&
                      cnt == 16'd0;
  assign startBitWr = ctrlWr & regWrData[`CTRL_START];
  assign stopBitWr  = ctrlWr & regWrData[`CTRL_STOP];
  assign aligned    = haveRise && (startPhase <= 16'd1 ||
                      startPhase == `CONV_PERIOD - 16'd1); //RULE_08
  assign goIdle     = (actMode == adccs_pkg::MD_ONESHOT) ||
                      (actMode == adccs_pkg::MD_STSTOP && stopPend); //RULE_09

  always_comb begin
    unique case (actMode)
      adccs_pkg::MD_STSTOP, adccs_pkg::MD_ONESHOT:
        goStart = startRise | startBitWr | (cfgWr & busy); //RULE_04 RULE_12 RULE_15
      default:
        goStart = cfgWr | (startRise & ~aligned) | ~busy; //RULE_07 RULE_08 RULE_03
    endcase
  end

  // phase since the last start rise, modulo one conversion period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      startPhase <= 16'd0;
      haveRise   <= 1'b0;
    end else if (softRst || cfgWr) begin
      startPhase <= 16'd0;
      haveRise   <= 1'b0;
    end else if (startRise) begin
      startPhase <= 16'd1;
      haveRise   <= 1'b1;
    end else if (startPhase == `CONV_PERIOD - 16'd1) begin
      startPhase <= 16'd0;
    end else begin
      startPhase <= startPhase + 16'd1;
    end
  end

  // settings are frozen at each restart
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      actMode  <= adccs_pkg::MD_SYNC;
      actOfs   <= 24'h000000;
      actGain  <= `GAIN_UNITY;
      actRes24 <= 1'b1;
      actPd    <= 1'b0;
    end else if (softRst) begin
      actMode  <= adccs_pkg::MD_SYNC;
      actOfs   <= 24'h000000;
      actGain  <= `GAIN_UNITY;
      actRes24 <= 1'b1;
      actPd    <= 1'b0;
    end else if (goStart) begin
      actMode  <= adccs_pkg::adccs_mode_t'(setB[1:0]); //RULE_26
      actOfs   <= ofsReg;
      actGain  <= gainReg;
      actRes24 <= setC[`SETC_RES24];
      actPd    <= setB[`SETB_PD];
    end
  end

  // the stop bit only matters in start/stop mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      stopPend <= 1'b0;
    else if (softRst || goStart)
      stopPend <= 1'b0;
    else if (actMode == adccs_pkg::MD_STSTOP && (startFall || stopBitWr))
      stopPend <= 1'b1; //RULE_09 RULE_16
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= adccs_pkg::ST_IDLE;
      cnt   <= 16'd0;
    end else if (softRst) begin
      state <= adccs_pkg::ST_IDLE;
      cnt   <= 16'd0;
    end else if (goStart) begin
      state <= adccs_pkg::ST_DELAY; //RULE_18
      cnt   <= {13'h0000, setC[2:0]} * `DLY_UNIT + (standbyOn ? `STBY_EXTRA : 16'd0);
    end else begin
      unique case (state)
        adccs_pkg::ST_IDLE: ;
        adccs_pkg::ST_DELAY: begin
          if (cnt == 16'd0) begin
            state <= adccs_pkg::ST_SETTLE;
            cnt   <= `FILT_LAT - 16'd1; //RULE_06
          end else begin
            cnt <= cnt - 16'd1;
          end
        end
        adccs_pkg::ST_SETTLE, adccs_pkg::ST_RUN: begin
          if (cnt != 16'd0) begin
            cnt <= cnt - 16'd1;
          end else if (goIdle) begin
            state <= adccs_pkg::ST_IDLE; //RULE_15 RULE_09
          end else begin
            state <= adccs_pkg::ST_RUN;
            cnt   <= `CONV_PERIOD - 16'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      standbyOn <= 1'b0;
    else
      standbyOn <= actPd && state == adccs_pkg::ST_IDLE && !goStart; //RULE_24
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      resultData <= 24'h000000;
    else if (softRst)
      resultData <= 24'h000000;
    else if (done)
      resultData <= calibrate(rawData, actOfs, actGain, actRes24); //RULE_19 RULE_20
  end

  // data-ready; a start always wins, so a missed readout cannot hold it low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resultAvailableN <= 1'b1;
      holdCnt          <= 2'd0;
    end else if (softRst) begin
      resultAvailableN <= 1'b1;
      holdCnt          <= 2'd0;
    end else if (goStart) begin
      resultAvailableN <= 1'b1; //RULE_11 RULE_15
      holdCnt          <= 2'd0;
    end else if (done) begin
      resultAvailableN <= 1'b0; //RULE_11
      holdCnt          <= (goIdle && actPd) ? `RESULT_AVAILABLE_N_HOLD : 2'd0;
    end else if (holdCnt != 2'd0) begin
      holdCnt <= holdCnt - 2'd1;
      if (holdCnt == 2'd1)
        resultAvailableN <= 1'b1; //RULE_13 RULE_17
    end else if (busy && state != adccs_pkg::ST_DELAY && cnt == 16'd1) begin
      resultAvailableN <= 1'b1; //RULE_14
    end else if (readEvt && actMode != adccs_pkg::MD_ONESHOT) begin
      resultAvailableN <= 1'b1; //RULE_13
    end
  end

  restart_cfg_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_03
    (cfgWr && busy) |=> (state == adccs_pkg::ST_DELAY && resultAvailableN))
    else $error("config write did not restart");

  sync_keep_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_08
    (actMode == adccs_pkg::MD_SYNC && busy && startRise && aligned && !cfgWr)
      |=> state != adccs_pkg::ST_DELAY)
    else $error("aligned start caused resync");

  done_low_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_11
    (done && !goStart) |=> !resultAvailableN)
    else $error("data-ready not low at result");

  standby_hold_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_13
    (done && goIdle && actPd && !goStart) ##1 (!goStart)[*3]
      |=> resultAvailableN && !$past(resultAvailableN, 3))
    else $error("standby data-ready hold wrong");

  oneshot_keep_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_16
    (actMode == adccs_pkg::MD_ONESHOT && busy && !done && !goStart) |=> busy)
    else $error("one-shot conversion interrupted");

  delay_once_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_18
    (state == adccs_pkg::ST_RUN && !goStart) |=> state != adccs_pkg::ST_DELAY)
    else $error("later conversion delayed");

  latency_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_06
    (state == adccs_pkg::ST_DELAY ##1 state == adccs_pkg::ST_SETTLE)
      |-> cnt == `FILT_LAT - 16'd1)
    else $error("first result latency wrong");

  freeze_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_26
    goStart |=> (actGain == $past(gainReg) && actOfs == $past(ofsReg)))
    else $error("settings not frozen at restart");

  standby_a: assert property (@(posedge mclk) disable iff (!nrst || softRst) //RULE_24
    (state == adccs_pkg::ST_DELAY) |-> !standbyOn)
    else $error("standby while converting");

endmodule

// >>> tb/adccs_host_model.sv
// host side model: serial clock, chip select and serial data frames
`timescale 1ns/1ps
module adccs_host_model (
  output logic sclk,
  output logic csN,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    sdi  = 1'b0;
  end

  // sclk idles low and runs only inside a frame; data changes on the rising edge
  task automatic frame(input int nOnes, input int nZeros);
    int i;
    #3.3;
    csN = 1'b0;
    #20;
    for (i = 0; i < nOnes + nZeros; i++) begin
      sclk = 1'b1;
      sdi  = (i < nOnes);
      #7.5;
      sclk = 1'b0;
      #7.5;
    end
    #20;
    csN = 1'b1;
    // no pull on the data line, so it must not keep the last bit
    sdi = ~sdi;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the conversion control and calibration block
`timescale 1ns/1ps
`include "adccs_params.svh"
module tb;
  typedef struct {
    logic [23:0] data;
    int          lat;
    int          hold;
  } adccs_note_t;

  logic        mclk = 1'b0;
  logic        nrst;
  logic        sclk;
  logic        csN;
  logic        sdi;
  logic        startPin;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic [23:0] rawData;
  logic [23:0] resultData;
  logic        resultAvailableN;
  logic        standbyOn;
  logic        deviceResetPulse;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  int          nPulse = 0;
  int          tLast;
  int          tRef;
  logic        prevN = 1'b1;
  logic [23:0] ofs;
  logic [23:0] gain;
  adccs_note_t notes[$];
  adccs_note_t nt;

  always #2 mclk = ~mclk;

  adccs_core adccs_core_i (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .csN(csN), .sdi(sdi), .startPin(startPin),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .rawData(rawData), .resultData(resultData),
    .resultAvailableN(resultAvailableN), .standbyOn(standbyOn),
    .deviceResetPulse(deviceResetPulse)
  );

  adccs_host_model adccs_host_model_i (.sclk(sclk), .csN(csN), .sdi(sdi));

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (deviceResetPulse === 1'b1)
      nPulse <= nPulse + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_word(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [23:0] cal(input logic [23:0] raw, input logic [23:0] o,
                                      input logic [23:0] g, input logic r24);
    longint p;
    longint q;
    longint hi;
    p = (longint'($signed(raw)) - longint'($signed(o))) * longint'({40'd0, g});
    hi = r24 ? 64'sd8388607 : 64'sd32767;
    q = r24 ? (p + 64'sd2097152) >>> 22 : (p + 64'sd536870912) >>> 30;
    q = (q > hi) ? hi : q;
    q = (q < -hi - 1) ? -hi - 1 : q;
    return q[23:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge mclk);
    regWrEn = 1'b0;
    tLast = cyc;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(negedge mclk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge mclk);
    regRdEn = 1'b0;
    @(negedge mclk);
    cmp_word(nm, {16'h0, e}, {16'h0, regRdData});
  endtask

  task automatic wait_notes;
    int k;
    for (k = 0; k < 3000 && notes.size() > 0; k++)
      @(negedge mclk);
    if (notes.size() > 0) begin
      n_mismatch++;
      $display("MISMATCH pendingResults expected 0 seen %0d", notes.size());
      notes.delete();
    end
    repeat (5) @(negedge mclk);
  endtask

  // results with no pending note (free-running conversions) are ignored
  initial forever begin
    @(posedge mclk);
    if (prevN === 1'b1 && resultAvailableN === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      cmp_word("resultData", nt.data, resultData);
      cmp_flag("latency", 1'b1, cyc >= tRef + nt.lat - 1 && cyc <= tRef + nt.lat + 1);
      if (nt.hold > 0) begin
        @(negedge mclk);
        cmp_flag("drdyLow", 1'b0, resultAvailableN);
        repeat (2) @(negedge mclk);
        cmp_flag("drdyHold", nt.hold == 1, resultAvailableN);
      end
    end
    prevN = resultAvailableN;
  end

  initial begin : main
    int i;
    int j;
    logic [7:0] b;
    nrst = 1'b0;
    startPin = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    rawData = 24'h000000;
    void'($urandom(93168));
    rawData = 24'($urandom);
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    tRef = cyc;
    notes.push_back('{cal(rawData, 24'h0, `GAIN_UNITY, 1'b1), 162, 0});
    wait_notes;
    rd(`ADDR_GN_HI, 8'h40, "gainHighReset");
    rd(`ADDR_OFS_HI, 8'h00, "offsetHighReset");
    rd(`ADDR_SETC, `SETC_RST, "setupCReset");
    rd(8'h1f, 8'h00, "unmappedRead");
    wr(`ADDR_SETB, 8'h02);
    repeat (400) @(negedge mclk);
    ofs = 24'($signed(16'($urandom)));
    gain = 24'h380000 + 24'($urandom_range(0, 24'h0fffff));
    for (j = 0; j < 6; j++) begin
      b = (j < 3) ? ofs[23 - 8 * j -: 8] : gain[47 - 8 * j -: 8];
      wr(8'h09 + 8'(j), b);
      rd(8'h09 + 8'(j), b, "calByte");
    end
    for (i = 0; i < 4; i++) begin
      rawData = 24'($urandom);
      wr(`ADDR_SETB, {5'd0, i == 3, 2'b10});
      wr(`ADDR_SETC, {4'd0, i[0], 3'(i * 2)});
      wr(`ADDR_CTRL, 8'h00);
      wr(`ADDR_CTRL, 8'h01);
      tRef = tLast;
      repeat (40) @(negedge mclk);
      if (i == 0)
        wr(`ADDR_GN_LO, gain[7:0]);
      if (i == 1)
        wr(`ADDR_CTRL, 8'h02);
      if (i == 2)
        wr(`ADDR_CTRL, 8'h01);
      if (i != 1)
        tRef = tLast;
      notes.push_back('{cal(rawData, ofs, gain, i[0]), 162 + 64 * i,
                        (i == 3) ? 1 : 2});
      wait_notes;
      cmp_flag("standbyOn", i == 3, standbyOn);
    end
    wr(`ADDR_SETB, 8'h01);
    wr(`ADDR_SETC, 8'h08);
    rawData = 24'($urandom);
    @(negedge mclk);
    startPin = 1'b1;
    tRef = cyc;
    notes.push_back('{cal(rawData, ofs, gain, 1'b1), 188, 0});
    notes.push_back('{cal(rawData, ofs, gain, 1'b1), 252, 0});
    wait_notes;
    startPin = 1'b0;
    repeat (200) @(negedge mclk);
    cmp_flag("drdyStopped", 1'b0, resultAvailableN);
    adccs_host_model_i.frame(0, 8);
    repeat (20) @(negedge mclk);
    cmp_flag("drdyAfterRead", 1'b1, resultAvailableN);
    adccs_host_model_i.frame(1022, 1);
    repeat (20) @(negedge mclk);
    cmp_word("resetCount", 24'd0, 24'(nPulse));
    adccs_host_model_i.frame(1023, 1);
    repeat (20) @(negedge mclk);
    cmp_word("resetCount", 24'd1, 24'(nPulse));
    wr(`ADDR_GN_HI, 8'h12);
    adccs_host_model_i.frame(1024, 0);
    repeat (20) @(negedge mclk);
    cmp_word("resetCount", 24'd2, 24'(nPulse));
    rd(`ADDR_GN_HI, 8'h40, "gainHighAfterReset");
    close_out();
  end
endmodule
